//--- hw/opc_clkdiv.sv
// Divides a synchronised oscillator level by 1, 2, 4 or 8
`timescale 1ns/10ps
module opc_clkdiv (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_src,
  input wire logic [1:0] i_div,
  output logic o_clk
);
  typedef struct packed {
    logic prev;
    logic [2:0] cnt;
    logic out;
  } opc_div_st_s;

  opc_div_st_s st_reg;
  opc_div_st_s st_next;

  // Source must be well under half the system clock, or edges are lost
  always_comb begin
    st_next = st_reg;
    if (i_ce) begin
      st_next.prev = i_src;
      if (i_src && !st_reg.prev) begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
      case (i_div)
        2'h0: st_next.out = i_src;
        2'h1: st_next.out = st_reg.cnt[0];
        2'h2: st_next.out = st_reg.cnt[1];
        2'h3: st_next.out = st_reg.cnt[2];
        default: st_next.out = i_src;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_clk = st_reg.out;
endmodule // opc_clkdiv

//--- hw/opc_output_port.sv
// Output port control: pin data, float control, special outputs, buzzer one-shot
// Notes on behaviour
// - A set float bit floats its pins; clear drives them push-pull.
// - Reset clears every float bit, so all pins start driven.
// - Ports 0 and 1 float per nibble; ports 2, 3 and buzzer pins per pin.
// - Two spare bits in the first float register are plain storage.
// - A data bit of 1 drives its pin high, 0 drives low; reads back.
// - Reset sets all data bits to 1 except the buzzer pin bit, cleared.
// - The spare data register is storage only, resetting to all ones.
// - With the inverted-signal option, the pin's data bit no longer reaches the pin.
// - Data bits of pins given to bus signals only store; bus drives pin.
// - Sync clock enable routes the LCD sync clock to its pin, else high.
// - Frame enable routes the LCD frame signal to its pin, else high.
// - Writing 1 to force-stop ends a one-shot; it always reads 0.
// - Duration select picks 125 ms when set, 31.25 ms when clear.
// - Timer enable drives timer clock and its inverse; else high and low.
// - Three-bit select picks source and divide by 1, 2, 4 or 8.
// - Divided clock enable drives the divided clock on its pin, else high.
// - Trigger works only with continuous buzzer off; retrigger restarts; reads busy.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module opc_output_port #(
  parameter logic [opc_pkg::SHOT_CNT_W-1:0] P_SHOT_LONG_CYC = opc_pkg::SHOT_LONG_CYC,
  parameter logic [opc_pkg::SHOT_CNT_W-1:0] P_SHOT_SHORT_CYC = opc_pkg::SHOT_SHORT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire opc_pkg::opc_special_s i_special,
  input wire opc_pkg::opc_option_s i_option,
  input wire opc_pkg::opc_pins_s i_bus_pin_sel,
  input wire opc_pkg::opc_pins_s i_bus_pin_val,
  output opc_pkg::opc_pins_s o_pin_out,
  output opc_pkg::opc_pins_s o_pin_oe
);
  import opc_pkg::*;

  typedef struct packed {
    logic lcd_sync_en;
    logic lcd_frame_en;
    logic timer_en;
    logic [2:0] div_sel;
    logic div_en;
    logic buz_en;
    logic dur_sel;
    logic [SHOT_CNT_W-1:0] shot_cnt;
    logic [7:0] hiz_a;
    logic [7:0] hiz2;
    logic [7:0] hiz3;
    logic [7:0] dat0;
    logic [7:0] dat1;
    logic [7:0] dat2;
    logic [7:0] dat3;
    logic [7:0] rsv;
    logic [1:0] dat5;
    logic wr_pend;
    logic rd_pend;
    opc_reg_e ap_sel;
    logic [7:0] rdata;
    opc_pins_s pin_out;
    opc_pins_s pin_oe;
  } opc_st_s;

  opc_st_s st_reg;
  opc_st_s st_next;
  opc_special_s sp;
  logic divided_clock_out;
  logic shot_busy;
  logic buz_act;
  logic bz_gated;
  logic [7:0] wd;
  opc_pins_s po;

  // Word-aligned index decode; anything else falls to the empty slot
  function automatic opc_reg_e reg_decode(input logic [31:0] a);
    opc_reg_e s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && a[31:18] == 14'h0) begin
      case (a[17:2])
        IDX_LCD_CTRL: s = SEL_LCD;
        IDX_TMR_CTRL: s = SEL_TMR;
        IDX_DIV_CTRL: s = SEL_DIV;
        IDX_BUZ_CTRL: s = SEL_BUZ;
        IDX_HIZ_A: s = SEL_HZA;
        IDX_HIZ_P2: s = SEL_HZ2;
        IDX_HIZ_P3: s = SEL_HZ3;
        IDX_DAT_P0: s = SEL_D0;
        IDX_DAT_P1: s = SEL_D1;
        IDX_DAT_P2: s = SEL_D2;
        IDX_DAT_P3: s = SEL_D3;
        IDX_RSV_DAT: s = SEL_RSV;
        IDX_DAT_P5: s = SEL_D5;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [7:0] rd_value(input opc_reg_e s, input opc_st_s x);
    logic [7:0] v;
    v = 8'h00;
    case (s)
      SEL_LCD: begin
        v[LCD_SYNC_BIT] = x.lcd_sync_en;
        v[LCD_FRAME_BIT] = x.lcd_frame_en;
      end
      SEL_TMR: v[TMR_EN_BIT] = x.timer_en;
      SEL_DIV: begin
        v[DIV_SEL_LSB+:3] = x.div_sel;
        v[DIV_EN_BIT] = x.div_en;
      end
      SEL_BUZ: begin
        v[BUZ_EN_BIT] = x.buz_en;
        v[DUR_BIT] = x.dur_sel;
        v[SHOT_BIT] = (x.shot_cnt != '0);
      end
      SEL_HZA: v = x.hiz_a;
      SEL_HZ2: v = x.hiz2;
      SEL_HZ3: v = x.hiz3;
      SEL_D0: v = x.dat0;
      SEL_D1: v = x.dat1;
      SEL_D2: v = x.dat2;
      SEL_D3: v = x.dat3;
      SEL_RSV: v = x.rsv;
      SEL_D5: v[1:0] = x.dat5;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  opc_sync #(
    .W($bits(opc_special_s))
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_special),
    .o_sync(sp)
  );

  // Source select by the top bit, divide ratio by the low two
  opc_clkdiv u_div (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_src(st_reg.div_sel[2] ? sp.fosc3 : sp.fosc1),
    .i_div(st_reg.div_sel[1:0]),
    .o_clk(divided_clock_out)
  );

  assign shot_busy = (st_reg.shot_cnt != '0);
  assign buz_act = st_reg.buz_en | shot_busy;
  assign bz_gated = buz_act & sp.buzzer_signal;
  assign wd = i_hwdata[7:0];

  always_comb begin
    st_next = st_reg;
    po = st_reg.pin_out;
    if (i_ce) begin
      st_next.wr_pend = 1'b0;
      st_next.rd_pend = 1'b0;
      if (shot_busy) begin
        st_next.shot_cnt = st_reg.shot_cnt - SHOT_CNT_W'(1);
      end
      // Read data is fetched a cycle after the address so a write just ahead is seen
      if (st_reg.rd_pend) begin
        st_next.rdata = rd_value(st_reg.ap_sel, st_reg);
      end
      if (st_reg.wr_pend) begin
        case (st_reg.ap_sel)
          SEL_LCD: begin
            st_next.lcd_sync_en = wd[LCD_SYNC_BIT];
            st_next.lcd_frame_en = wd[LCD_FRAME_BIT];
          end
          SEL_TMR: st_next.timer_en = wd[TMR_EN_BIT];
          SEL_DIV: begin
            st_next.div_sel = wd[DIV_SEL_LSB+:3];
            st_next.div_en = wd[DIV_EN_BIT];
          end
          SEL_BUZ: begin
            st_next.buz_en = wd[BUZ_EN_BIT];
            st_next.dur_sel = wd[DUR_BIT];
            if (wd[STOP_BIT]) begin
              st_next.shot_cnt = '0;
            end else if (wd[SHOT_BIT] && !st_reg.buz_en) begin
              st_next.shot_cnt = wd[DUR_BIT] ? P_SHOT_LONG_CYC : P_SHOT_SHORT_CYC;
            end
          end
          SEL_HZA: st_next.hiz_a = wd;
          SEL_HZ2: st_next.hiz2 = wd;
          SEL_HZ3: st_next.hiz3 = wd;
          SEL_D0: st_next.dat0 = wd;
          SEL_D1: st_next.dat1 = wd;
          SEL_D2: st_next.dat2 = wd;
          SEL_D3: st_next.dat3 = wd;
          SEL_RSV: st_next.rsv = wd;
          SEL_D5: st_next.dat5 = wd[1:0];
          default: st_next.rdata = st_reg.rdata;
        endcase
      end
      if (i_hsel && i_htrans[1] && i_hready) begin
        st_next.ap_sel = reg_decode(i_haddr);
        st_next.wr_pend = i_hwrite;
        st_next.rd_pend = !i_hwrite;
      end
      // Float control, nibble-wide for ports 0 and 1
      st_next.pin_oe.r0 = ~{{4{st_reg.hiz_a[HZA_P0H]}}, {4{st_reg.hiz_a[HZA_P0L]}}};
      st_next.pin_oe.r1 = ~{{4{st_reg.hiz_a[HZA_P1H]}}, {4{st_reg.hiz_a[HZA_P1L]}}};
      st_next.pin_oe.r2 = ~st_reg.hiz2;
      st_next.pin_oe.r3 = ~st_reg.hiz3;
      st_next.pin_oe.r5 = ~st_reg.hiz_a[HZA_R51:HZA_R50];
      po.r0 = st_reg.dat0;
      po.r1 = st_reg.dat1;
      po.r2 = st_reg.dat2;
      po.r3 = st_reg.dat3;
      // Specials on R25, R27, R34 and non-inverted R26 are ANDed with the data bit, which software must leave at 1; R50 is ORed with its bit
      po.r2[R25_BIT] = st_reg.dat2[R25_BIT] & (~st_reg.lcd_sync_en | sp.lcd_sync_clock);
      po.r2[R27_BIT] = st_reg.dat2[R27_BIT] & (~st_reg.timer_en | sp.timer_clock_out);
      if (i_option.r26_timer_inv) begin
        po.r2[R26_BIT] = st_reg.timer_en & ~sp.timer_clock_out;
      end else begin
        po.r2[R26_BIT] = st_reg.dat2[R26_BIT] & (~st_reg.lcd_frame_en | sp.lcd_frame_signal);
      end
      po.r3[R34_BIT] = st_reg.dat3[R34_BIT] & (~st_reg.div_en | divided_clock_out);
      po.r5[0] = st_reg.dat5[0] | bz_gated;
      po.r5[1] = i_option.r51_buzzer_inv ? ~bz_gated : st_reg.dat5[1];
      st_next.pin_out = (po & ~i_bus_pin_sel) | (i_bus_pin_val & i_bus_pin_sel);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.hiz_a <= HIZ_RST;
      st_reg.hiz2 <= HIZ_RST;
      st_reg.hiz3 <= HIZ_RST;
      st_reg.dat0 <= DAT_RST;
      st_reg.dat1 <= DAT_RST;
      st_reg.dat2 <= DAT_RST;
      st_reg.dat3 <= DAT_RST;
      st_reg.rsv <= DAT_RST;
      st_reg.dat5 <= DAT5_RST;
      st_reg.pin_out <= {DAT5_RST, DAT_RST, DAT_RST, DAT_RST, DAT_RST};
      st_reg.pin_oe <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Word transfers only; narrower sizes land in the low byte as well
  // Held low while frozen, so the master never moves past a transfer that was not taken
  assign o_hreadyout = i_ce & !st_reg.rd_pend;
  assign o_hresp = 1'b0;
  assign o_hrdata = {24'h0, st_reg.rdata};
  assign o_pin_out = st_reg.pin_out;
  assign o_pin_oe = st_reg.pin_oe;

  logic commit_buz;
  assign commit_buz = i_ce && st_reg.wr_pend && st_reg.ap_sel == SEL_BUZ;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_hiz_float;
    i_ce |=> (o_pin_oe.r2 == ~$past(st_reg.hiz2)) && (o_pin_oe.r0[7:4] == {4{~$past(st_reg.hiz_a[HZA_P0H])}});
  endproperty
  a_hiz_float: assert property (p_hiz_float) else $error("float control not on pins");

  property p_data_drive;
    i_ce && i_bus_pin_sel.r3[3:0] == 4'h0 |=> o_pin_out.r3[3:0] == $past(st_reg.dat3[3:0]);
  endproperty
  a_data_drive: assert property (p_data_drive) else $error("pin level differs from data");

  property p_r51_option;
    i_ce && i_option.r51_buzzer_inv && !buz_act && !i_bus_pin_sel.r5[1] |=> o_pin_out.r5[1];
  endproperty
  a_r51_option: assert property (p_r51_option) else $error("inverted buzzer pin not high");

  property p_bus_pin;
    i_ce && i_bus_pin_sel.r1[0] |=> o_pin_out.r1[0] == $past(i_bus_pin_val.r1[0]);
  endproperty
  a_bus_pin: assert property (p_bus_pin) else $error("bus pin not under bus control");

  property p_sync_off;
    i_ce && !st_reg.lcd_sync_en && st_reg.dat2[R25_BIT] && !i_bus_pin_sel.r2[R25_BIT]
      |=> o_pin_out.r2[R25_BIT];
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync pin not static high");

  property p_stop_wins;
    commit_buz && wd[STOP_BIT] |=> st_reg.shot_cnt == '0 ##1 !shot_busy;
  endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("force stop did not end one-shot");

  property p_stop_reads0;
    i_ce && st_reg.rd_pend && st_reg.ap_sel == SEL_BUZ |=> !o_hrdata[STOP_BIT];
  endproperty
  a_stop_reads0: assert property (p_stop_reads0) else $error("force stop read as one");

  property p_short_load;
    commit_buz && !wd[STOP_BIT] && wd[SHOT_BIT] && !wd[DUR_BIT] && !st_reg.buz_en
      |=> st_reg.shot_cnt == P_SHOT_SHORT_CYC;
  endproperty
  a_short_load: assert property (p_short_load) else $error("short one-shot length wrong");

  property p_trig_blocked;
    commit_buz && st_reg.buz_en && !shot_busy |=> !shot_busy;
  endproperty
  a_trig_blocked: assert property (p_trig_blocked) else $error("trigger taken while continuous");

  property p_timer_off;
    i_ce && i_option.r26_timer_inv && !st_reg.timer_en && !i_bus_pin_sel.r2[R26_BIT]
      |=> !o_pin_out.r2[R26_BIT];
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("inverted timer pin not low");

  property p_buz_off;
    i_ce && !buz_act && !i_bus_pin_sel.r5[0] |=> o_pin_out.r5[0] == $past(st_reg.dat5[0]);
  endproperty
  a_buz_off: assert property (p_buz_off) else $error("buzzer pin not at data level");

  property p_unmapped;
    i_ce && st_reg.rd_pend && st_reg.ap_sel == SEL_NONE |=> o_hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_read_wait;
    i_ce && i_hsel && i_htrans[1] && i_hready && !i_hwrite |=> !o_hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state missing");

  c_trigger: cover property (commit_buz && wd[SHOT_BIT] && !st_reg.buz_en);
  c_stop: cover property (commit_buz && wd[STOP_BIT] && shot_busy);
  c_read: cover property (st_reg.rd_pend ##1 o_hreadyout);
  c_divided_clock_out: cover property (st_reg.div_en && $rose(divided_clock_out));
endmodule // opc_output_port

//--- hw/opc_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module opc_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } opc_sync_st_s;

  opc_sync_st_s st_reg;
  opc_sync_st_s st_next;

  always_comb begin
    st_next = st_reg;
    if (i_ce) begin
      st_next.s1 = i_async;
      st_next.s2 = st_reg.s1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.s2;
endmodule // opc_sync

//--- shared/opc_pkg.sv
// Shared constants and carrier types for the output port control block
package opc_pkg;
  // Clock and one-shot buzzer timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SHOT_LONG_NS = 125000000;
  localparam int unsigned SHOT_SHORT_NS = 31250000;
  localparam int unsigned SHOT_CNT_W = 23;
  localparam logic [SHOT_CNT_W-1:0] SHOT_LONG_CYC = SHOT_CNT_W'(SHOT_LONG_NS / CLK_PERIOD_NS);
  localparam logic [SHOT_CNT_W-1:0] SHOT_SHORT_CYC = SHOT_CNT_W'(SHOT_SHORT_NS / CLK_PERIOD_NS);

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_LCD_CTRL = 16'hff10;
  localparam logic [15:0] IDX_TMR_CTRL = 16'hff30;
  localparam logic [15:0] IDX_DIV_CTRL = 16'hff40;
  localparam logic [15:0] IDX_BUZ_CTRL = 16'hff44;
  localparam logic [15:0] IDX_HIZ_A = 16'hff70;
  localparam logic [15:0] IDX_HIZ_P2 = 16'hff71;
  localparam logic [15:0] IDX_HIZ_P3 = 16'hff72;
  localparam logic [15:0] IDX_DAT_P0 = 16'hff73;
  localparam logic [15:0] IDX_DAT_P1 = 16'hff74;
  localparam logic [15:0] IDX_DAT_P2 = 16'hff75;
  localparam logic [15:0] IDX_DAT_P3 = 16'hff76;
  localparam logic [15:0] IDX_RSV_DAT = 16'hff77;
  localparam logic [15:0] IDX_DAT_P5 = 16'hff78;

  // Field positions
  localparam int unsigned LCD_SYNC_BIT = 4;
  localparam int unsigned LCD_FRAME_BIT = 3;
  localparam int unsigned TMR_EN_BIT = 2;
  localparam int unsigned DIV_EN_BIT = 3;
  localparam int unsigned DIV_SEL_LSB = 4;
  localparam int unsigned BUZ_EN_BIT = 0;
  localparam int unsigned DUR_BIT = 4;
  localparam int unsigned SHOT_BIT = 5;
  localparam int unsigned STOP_BIT = 6;
  localparam int unsigned HZA_P0L = 0;
  localparam int unsigned HZA_P0H = 1;
  localparam int unsigned HZA_P1L = 2;
  localparam int unsigned HZA_P1H = 3;
  localparam int unsigned HZA_RSV_LSB = 4;
  localparam int unsigned HZA_R50 = 6;
  localparam int unsigned HZA_R51 = 7;
  localparam int unsigned R25_BIT = 5;
  localparam int unsigned R26_BIT = 6;
  localparam int unsigned R27_BIT = 7;
  localparam int unsigned R34_BIT = 4;

  // Values after reset
  localparam logic [7:0] HIZ_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'hff;
  localparam logic [1:0] DAT5_RST = 2'h2;

  typedef struct packed {
    logic [1:0] r5;
    logic [7:0] r3;
    logic [7:0] r2;
    logic [7:0] r1;
    logic [7:0] r0;
  } opc_pins_s;

  typedef struct packed {
    logic lcd_sync_clock;
    logic lcd_frame_signal;
    logic timer_clock_out;
    logic buzzer_signal;
    logic fosc1;
    logic fosc3;
  } opc_special_s;

  typedef struct packed {
    logic r26_timer_inv;
    logic r51_buzzer_inv;
  } opc_option_s;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0, SEL_LCD = 4'h1, SEL_TMR = 4'h2, SEL_DIV = 4'h3,
    SEL_BUZ = 4'h4, SEL_HZA = 4'h5, SEL_HZ2 = 4'h6, SEL_HZ3 = 4'h7,
    SEL_D0 = 4'h8, SEL_D1 = 4'h9, SEL_D2 = 4'ha, SEL_D3 = 4'hb,
    SEL_RSV = 4'hc, SEL_D5 = 4'hd
  } opc_reg_e;
endpackage

//--- sim/opc_load_model.sv
// Model of the external loads on the output pins, resolving each pin's level
`timescale 1ns/10ps
module opc_load_model (
  input wire logic i_mclk,
  input wire opc_pkg::opc_pins_s i_pin_out,
  input wire opc_pkg::opc_pins_s i_pin_oe,
  output opc_pkg::opc_pins_s o_level
);
  import opc_pkg::*;
  opc_pins_s last_reg;
  // No pulls on the loads: a released pin shows the inverse of its last driven level
  initial last_reg = '0;
  always @(posedge i_mclk) begin
    last_reg <= (i_pin_oe & i_pin_out) | (~i_pin_oe & last_reg);
  end
  assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & ~last_reg);
endmodule // opc_load_model

//--- sim/testbench.sv
// Self-checking testbench for the output port control block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  import opc_pkg::*;
  typedef struct packed {logic [67:0] val; logic [67:0] mask;} opc_note_s;
  localparam logic [33:0] ALL = 34'h3ffffffff;
  logic i_mclk, i_rst, i_ce, hsel, hwrite, probe, rd_pend, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans, d5;
  logic [2:0] hsize;
  logic [7:0] d [4];
  logic [7:0] h, h2, h3;
  logic [33:0] pin_out, pin_oe, pin_lvl, bus_sel, bus_val, oe;
  opc_special_s special;
  opc_option_s option;
  opc_note_s notes [$];
  opc_note_s nt;
  int n_mismatch, n_tests;
  logic [15:0] regs [13] = '{IDX_LCD_CTRL, IDX_TMR_CTRL, IDX_DIV_CTRL, IDX_BUZ_CTRL,
    IDX_HIZ_A, IDX_HIZ_P2, IDX_HIZ_P3, IDX_DAT_P0, IDX_DAT_P1, IDX_DAT_P2,
    IDX_DAT_P3, IDX_RSV_DAT, IDX_DAT_P5};
  logic [7:0] rstv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h02};

  opc_output_port #(.P_SHOT_LONG_CYC(23'd40), .P_SHOT_SHORT_CYC(23'd10)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_special(special), .i_option(option), .i_bus_pin_sel(bus_sel),
    .i_bus_pin_val(bus_val), .o_pin_out(pin_out), .o_pin_oe(pin_oe));
  opc_load_model loads (.i_mclk(i_mclk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .o_level(pin_lvl));

  initial i_mclk = 1'b0;
  always #10 i_mclk = ~i_mclk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [33:0] dv();
    return {d5, d[3], d[2], d[1], d[0]};
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Waits for hready high at a rising edge; a stuck bus ends the run
  task automatic wait_ready();
    int k;
    k = 0;
    @(negedge i_mclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_mismatch++;
        $display("wrong value at %0t: bus never ready", $time);
        summarize();
      end
      @(negedge i_mclk);
    end
    @(posedge i_mclk);
  endtask

  task automatic xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
    htrans <= 2'h2;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    xfer(idx, 1'b1, wd);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] ev);
    notes.push_back('{val: {60'h0, ev}, mask: {35'h0, 33'h1ffffffff}});
    xfer(idx, 1'b0, 8'h00);
  endtask

  task automatic pins(input logic [33:0] eoe, input logic [33:0] lvl, input logic [33:0] lm);
    @(posedge i_mclk);
    notes.push_back('{val: {eoe, lvl}, mask: {ALL, lm}});
    probe <= 1'b1;
    @(posedge i_mclk);
    probe <= 1'b0;
  endtask

  // Watches the outputs and takes the oldest note whenever a result shows
  always @(negedge i_mclk) begin
    if ((rd_pend && hreadyout === 1'b1) || probe === 1'b1) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("wrong value at %0t: result with no note", $time);
      end else begin
        nt = notes.pop_front();
        if (probe === 1'b1) begin
          `CHK({pin_oe, pin_lvl} & nt.mask, nt.val & nt.mask)
        end else begin
          `CHK({35'h0, hresp, hrdata} & nt.mask, nt.val & nt.mask)
        end
      end
      rd_pend = 1'b0;
    end
    if (htrans == 2'h2 && hreadyout === 1'b1 && !hwrite) rd_pend = 1'b1;
  end

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    special = '0;
    option = '0;
    bus_sel = '0;
    bus_val = '0;
    probe = 1'b0;
    rd_pend = 1'b0;
    n_tests = 0;
    n_mismatch = 0;
    seed = 32'h7d18;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 0; i < 13; i++) rd(regs[i], rstv[i]);
    pins(ALL, {2'b10, 32'hffffffff}, ALL);
    wr(16'hff79, 8'hff);
    rd(16'hff79, 8'h00);
    wr(IDX_RSV_DAT, 8'h5a);
    rd(IDX_RSV_DAT, 8'h5a);
    pins(ALL, {2'b10, 32'hffffffff}, ALL);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      d[i] = rnd();
      wr(regs[7 + i], d[i]);
    end
    d5 = 2'(rnd());
    wr(IDX_DAT_P5, {6'h3f, d5});
    for (int i = 0; i < 4; i++) rd(regs[7 + i], d[i]);
    rd(IDX_DAT_P5, {6'h0, d5});
    pins(ALL, dv(), ALL);
    bus_sel <= 34'h0f;
    bus_val <= 34'ha5;
    pins(ALL, {dv() & ~34'h0f} | 34'h05, ALL);
    rd(IDX_DAT_P0, d[0]);
    bus_sel <= '0;
    $display("test output data done");
    h = rnd();
    h2 = rnd();
    h3 = rnd();
    wr(IDX_HIZ_A, h);
    wr(IDX_HIZ_P2, h2);
    wr(IDX_HIZ_P3, h3);
    rd(IDX_HIZ_A, h);
    rd(IDX_HIZ_P2, h2);
    rd(IDX_HIZ_P3, h3);
    oe = ~{h[7:6], h3, h2, {4{h[3]}}, {4{h[2]}}, {4{h[1]}}, {4{h[0]}}};
    pins(oe, dv(), oe);
    for (int i = 4; i < 7; i++) wr(regs[i], 8'h00);
    pins(ALL, dv(), ALL);
    $display("test float control done");
    for (int i = 0; i < 4; i++) wr(regs[i], 8'hff);
    rd(IDX_LCD_CTRL, 8'h18);
    rd(IDX_TMR_CTRL, 8'h04);
    rd(IDX_DIV_CTRL, 8'h78);
    rd(IDX_BUZ_CTRL, 8'h11);
    for (int i = 0; i < 4; i++) wr(regs[i], 8'h00);
    $display("test unassigned bits done");
    d5 = 2'b00;
    wr(IDX_DAT_P5, 8'h00);
    special.buzzer_signal <= 1'b1;
    option.r51_buzzer_inv <= 1'b1;
    wr(IDX_BUZ_CTRL, 8'h20);
    rd(IDX_BUZ_CTRL, 8'h20);
    pins(ALL, {2'b01, 32'h0}, 34'h3 << 32);
    step(15);
    rd(IDX_BUZ_CTRL, 8'h00);
    pins(ALL, {2'b10, 32'h0}, 34'h3 << 32);
    wr(IDX_BUZ_CTRL, 8'h20);
    step(4);
    wr(IDX_BUZ_CTRL, 8'h20);
    step(3);
    rd(IDX_BUZ_CTRL, 8'h20);
    wr(IDX_BUZ_CTRL, 8'h30);
    wr(IDX_BUZ_CTRL, 8'h60);
    rd(IDX_BUZ_CTRL, 8'h00);
    wr(IDX_BUZ_CTRL, 8'h30);
    step(25);
    i_ce <= 1'b0;
    step(10);
    i_ce <= 1'b1;
    rd(IDX_BUZ_CTRL, 8'h30);
    step(8);
    rd(IDX_BUZ_CTRL, 8'h30);
    step(5);
    rd(IDX_BUZ_CTRL, 8'h10);
    wr(IDX_BUZ_CTRL, 8'h01);
    wr(IDX_BUZ_CTRL, 8'h21);
    rd(IDX_BUZ_CTRL, 8'h01);
    pins(ALL, {2'b01, 32'h0}, 34'h3 << 32);
    wr(IDX_BUZ_CTRL, 8'h00);
    pins(ALL, {2'b10, 32'h0}, 34'h3 << 32);
    $display("test buzzer done");
    wr(IDX_DAT_P2, 8'hff);
    wr(IDX_DAT_P3, 8'hff);
    wr(IDX_LCD_CTRL, 8'h10);
    step(4);
    pins(ALL, 34'h0, 34'h1 << 21);
    special.lcd_sync_clock <= 1'b1;
    step(4);
    pins(ALL, 34'h1 << 21, 34'h1 << 21);
    wr(IDX_LCD_CTRL, 8'h18);
    step(4);
    pins(ALL, 34'h1 << 21, 34'h3 << 21);
    special.lcd_frame_signal <= 1'b1;
    step(4);
    pins(ALL, 34'h3 << 21, 34'h3 << 21);
    option.r26_timer_inv <= 1'b1;
    wr(IDX_TMR_CTRL, 8'h04);
    step(4);
    pins(ALL, 34'h1 << 22, 34'h3 << 22);
    special.timer_clock_out <= 1'b1;
    step(4);
    pins(ALL, 34'h1 << 23, 34'h3 << 22);
    wr(IDX_TMR_CTRL, 8'h00);
    pins(ALL, 34'h1 << 23, 34'h3 << 22);
    wr(IDX_DIV_CTRL, 8'h08);
    step(4);
    pins(ALL, 34'h0, 34'h1 << 28);
    special.fosc1 <= 1'b1;
    step(4);
    pins(ALL, 34'h1 << 28, 34'h1 << 28);
    wr(IDX_DIV_CTRL, 8'h48);
    step(4);
    pins(ALL, 34'h0, 34'h1 << 28);
    wr(IDX_DIV_CTRL, 8'h00);
    pins(ALL, 34'h1 << 28, 34'h1 << 28);
    $display("test special outputs done");
    summarize();
  end
endmodule // testbench
